// ===== mif_pkg.sv
// package for the interrupt flag/enable block and its core-side partner
// assumes one core clock and an 8-bit special-function register port
package mif_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] TCON_ADDR      = 8'h88;
  localparam logic [7:0] EXT_PEND_ADDR  = 8'h91;
  localparam logic [7:0] SERIAL_PORT_CONTROL_ADDR      = 8'h98;
  localparam logic [7:0] IE_ADDR        = 8'ha8;
  localparam logic [7:0] IP_ADDR        = 8'hb8;
  localparam logic [7:0] WATCHDOG_CONTROL_ADDR     = 8'hd8;
  localparam logic [7:0] EXT_EN_ADDR    = 8'he8;
  localparam logic [7:0] EXT_PRIO_ADDR  = 8'hf8;
  localparam logic [7:0] TA_ADDR        = 8'hc7;

  // ----------------------------------------
  // reset values and keys
  // ----------------------------------------
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [7:0] TA_KEY1        = 8'haa;
  localparam logic [7:0] TA_KEY2        = 8'h55;
  localparam int         TA_WINDOW      = 3;

  // ----------------------------------------
  // bit positions
  // ----------------------------------------
  localparam int TC_IT0 = 0;
  localparam int TC_IE0 = 1;
  localparam int TC_IT1 = 2;
  localparam int TC_IE1 = 3;
  localparam int TC_TF0 = 5;
  localparam int TC_TF1 = 7;
  localparam int SC_RI  = 0;
  localparam int SC_TI  = 1;
  localparam int X_EXT2 = 0;
  localparam int X_EXT3 = 1;
  localparam int X_SRC4 = 2;
  localparam int X_NET  = 3;
  localparam int X_WDOG = 4;
  localparam int WD_EWT = 1;
  localparam int WD_IF  = 3;
  localparam int IE_EA  = 7;

  // source index = natural order (0 first)
  localparam int NSRC   = 9;
  localparam logic [3:0] NO_SRC = 4'hf;

  typedef logic [7:0] mif_vec_t [NSRC];
  localparam mif_vec_t VEC_ADDR = '{8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23,
                                    8'h43, 8'h4b, 8'h5b, 8'h63};

endpackage

// ===== mif_bus_if.sv
// interface joining the interrupt block and the core-side end
// assumes a single clock shared by both ends
`timescale 1ns/100ps
interface mif_bus_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       irq_req;
  logic [7:0] irq_vec;
  logic [3:0] irq_src;
  logic       irq_ack;
  logic       reti;

  modport dev  (input addr, wdata, wr, rd, irq_ack, reti,
                output rdata, irq_req, irq_vec, irq_src);
  modport core (output addr, wdata, wr, rd, irq_ack, reti,
                input rdata, irq_req, irq_vec, irq_src);
endinterface

// ===== mif_arbiter.sv
// priority pick among pending sources, two levels with nesting
// assumes pend/prio vectors ordered by natural order
`timescale 1ns/100ps
module mif_arbiter
  import mif_pkg::*;
#(
  parameter int N = NSRC
) (
  input  wire logic [N-1:0] pend_in,
  input  wire logic [N-1:0] hi_in,
  input  wire logic         in_lo_in,
  input  wire logic         in_hi_in,
  output logic              valid_out,
  output logic [3:0]        src_out
);
  logic [N-1:0] hi_req;
  logic [N-1:0] lo_req;
  logic [3:0]   hi_idx;
  logic [3:0]   lo_idx;

  assign hi_req = pend_in & hi_in;
  assign lo_req = pend_in & ~hi_in;

  function automatic logic [3:0] first_set(input logic [N-1:0] v);
    first_set = NO_SRC;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) first_set = 4'(i);
    end
  endfunction

  assign hi_idx = first_set(hi_req);
  assign lo_idx = first_set(lo_req);

  // high pre-empts low; nothing pre-empts high
  always_comb begin
    valid_out = 1'b0;
    src_out   = NO_SRC;
    if (!in_hi_in && |hi_req) begin
      valid_out = 1'b1;
      src_out   = hi_idx;
    end else if (!in_hi_in && !in_lo_in && |lo_req) begin
      valid_out = 1'b1;
      src_out   = lo_idx;
    end
  end
endmodule

// ===== mif_dev.sv
// interrupt flag, enable and priority registers of the controller
// assumes core acks one vector at a time and signals return (reti)
//
// Summary of operation
// - external 0/1 flags clear on vectoring in edge mode
// - timer flags set on overflow, clear on vectoring
// - uart rx bit0, tx bit1, shared request
// - extended enable bits 0,1,3,4 gate sources
// - software keeps source-4 bits at zero
// - extended priority bit one means high level
// - extended pending flags cleared by software only
// - watchdog control bit 3 holds watchdog flag
// - watchdog routine clears its flag itself
// - software-set enabled watchdog flag interrupts
// - watchdog flag writable via timed-access sequence
// - level mode flag follows external pin
// - global enable bit 7 masks all sources
`timescale 1ns/100ps
module mif_dev
  import mif_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic nrst_in,
  // core side
  mif_bus_if.dev    bus,
  // event sources (one-cycle pulses; ext pins active low levels)
  input  wire logic ext0_n_in,
  input  wire logic ext1_n_in,
  input  wire logic ext2_n_in,
  input  wire logic ext3_n_in,
  input  wire logic net_irq_n_in,
  input  wire logic tmr0_ovf_in,
  input  wire logic tmr1_ovf_in,
  input  wire logic uart_rx_in,
  input  wire logic uart_tx_in,
  input  wire logic wdog_evt_in,
  // status
  output logic      ta_open_out
);
  logic [7:0] tcon_r, serial_port_control_r, ie_r, ip_r, xen_r, xpri_r, xpend_r, watchdog_control_r;
  logic [7:0] tcon_nxt, serial_port_control_nxt, xpend_nxt, watchdog_control_nxt;
  logic [4:0] pin_r;
  logic [1:0] ta_stage_r;
  logic [1:0] ta_cnt_r;
  logic [7:0] rdata_r;
  logic       in_lo_r, in_hi_r, lo_pre_r;
  logic       req_r;
  logic [3:0] src_r;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire w_tcon  = bus.wr && bus.addr == TCON_ADDR;
  wire w_serial_port_control  = bus.wr && bus.addr == SERIAL_PORT_CONTROL_ADDR;
  wire w_ie    = bus.wr && bus.addr == IE_ADDR;
  wire w_ip    = bus.wr && bus.addr == IP_ADDR;
  wire w_xen   = bus.wr && bus.addr == EXT_EN_ADDR;
  wire w_xpri  = bus.wr && bus.addr == EXT_PRIO_ADDR;
  wire w_xpend = bus.wr && bus.addr == EXT_PEND_ADDR;
  wire w_ta    = bus.wr && bus.addr == TA_ADDR;
  wire ta_ok   = ta_stage_r == 2'd2;
  // watchdog flag is guarded: only taken inside the timed window
  wire w_watchdog_control = bus.wr && bus.addr == WATCHDOG_CONTROL_ADDR && ta_ok;
  wire ack     = bus.irq_ack;
  wire [3:0] ack_src = src_r;

  // falling edges, previous levels in pin_r; it resets high so no false edge
  wire fall2 = pin_r[0] && !ext2_n_in;
  wire fall3 = pin_r[1] && !ext3_n_in;
  wire falln = pin_r[2] && !net_irq_n_in;
  wire fall0 = pin_r[3] && !ext0_n_in;
  wire fall1 = pin_r[4] && !ext1_n_in;

  // ----------------------------------------
  // flag next-state
  // ----------------------------------------
  always_comb begin
    tcon_nxt = w_tcon ? bus.wdata : tcon_r;
    if (ack && ack_src == 4'd0) tcon_nxt[TC_IE0] = 1'b0;
    if (ack && ack_src == 4'd2) tcon_nxt[TC_IE1] = 1'b0;
    if (ack && ack_src == 4'd1) tcon_nxt[TC_TF0] = 1'b0;
    if (ack && ack_src == 4'd3) tcon_nxt[TC_TF1] = 1'b0;
    // edge mode latches an edge, so a pin held low cannot re-arm; level tracks
    if (tcon_r[TC_IT0]) begin
      if (fall0) tcon_nxt[TC_IE0] = 1'b1;
    end else begin
      tcon_nxt[TC_IE0] = !ext0_n_in;
    end
    if (tcon_r[TC_IT1]) begin
      if (fall1) tcon_nxt[TC_IE1] = 1'b1;
    end else begin
      tcon_nxt[TC_IE1] = !ext1_n_in;
    end
    if (tmr0_ovf_in) tcon_nxt[TC_TF0] = 1'b1;
    if (tmr1_ovf_in) tcon_nxt[TC_TF1] = 1'b1;

    serial_port_control_nxt = w_serial_port_control ? bus.wdata : serial_port_control_r;
    if (uart_rx_in) serial_port_control_nxt[SC_RI] = 1'b1;
    if (uart_tx_in) serial_port_control_nxt[SC_TI] = 1'b1;

    // no clear on vectoring; set beats software clear
    xpend_nxt = w_xpend ? {4'h0, bus.wdata[3:0]} : xpend_r;
    if (fall2) xpend_nxt[X_EXT2] = 1'b1;
    if (fall3) xpend_nxt[X_EXT3] = 1'b1;
    if (falln) xpend_nxt[X_NET]  = 1'b1;

    // software may set or clear the flag, event sets win
    watchdog_control_nxt = w_watchdog_control ? {4'h0, bus.wdata[3:0]} : watchdog_control_r;
    if (wdog_evt_in) watchdog_control_nxt[WD_IF] = 1'b1;
  end

  // ----------------------------------------
  // pending and enabled vector
  // ----------------------------------------
  logic [NSRC-1:0] raw, en, hi;
  assign raw = {watchdog_control_r[WD_IF], xpend_r[X_NET], xpend_r[X_EXT3], xpend_r[X_EXT2],
                serial_port_control_r[SC_RI] | serial_port_control_r[SC_TI], tcon_r[TC_TF1], tcon_r[TC_IE1],
                tcon_r[TC_TF0], tcon_r[TC_IE0]};
  assign en  = {xen_r[X_WDOG], xen_r[X_NET], xen_r[X_EXT3], xen_r[X_EXT2],
                ie_r[4:0]};
  assign hi  = {xpri_r[X_WDOG], xpri_r[X_NET], xpri_r[X_EXT3], xpri_r[X_EXT2],
                ip_r[4:0]};
  wire [NSRC-1:0] pend = ie_r[IE_EA] ? (raw & en) : '0;

  logic       arb_v;
  logic [3:0] arb_src;
  mif_arbiter #(.N(NSRC)) u_arb (
    .pend_in   (pend),
    .hi_in     (hi),
    .in_lo_in  (in_lo_r),
    .in_hi_in  (in_hi_r),
    .valid_out (arb_v),
    .src_out   (arb_src)
  );

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tcon_r  <= REG_RESET;
      serial_port_control_r  <= REG_RESET;
      ie_r    <= REG_RESET;
      ip_r    <= REG_RESET;
      xen_r   <= REG_RESET;
      xpri_r  <= REG_RESET;
      xpend_r <= REG_RESET;
      watchdog_control_r <= REG_RESET;
      pin_r   <= 5'h1f;
    end else begin
      tcon_r  <= tcon_nxt;
      serial_port_control_r  <= serial_port_control_nxt;
      xpend_r <= xpend_nxt;
      watchdog_control_r <= watchdog_control_nxt;
      pin_r   <= {ext1_n_in, ext0_n_in, net_irq_n_in, ext3_n_in, ext2_n_in};
      if (w_ie)   ie_r   <= bus.wdata;
      if (w_ip)   ip_r   <= {2'h0, bus.wdata[5:0]};
      if (w_xen)  xen_r  <= {3'h0, bus.wdata[4:0]};
      if (w_xpri) xpri_r <= {3'h0, bus.wdata[4:0]};
    end
  end

  // timed access: key1 then key2 opens a short write window
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ta_stage_r <= 2'd0;
      ta_cnt_r   <= 2'd0;
    end else if (w_ta && bus.wdata == TA_KEY1) begin
      ta_stage_r <= 2'd1;
      ta_cnt_r   <= 2'(TA_WINDOW);
    end else if (w_ta && ta_stage_r == 2'd1 && bus.wdata == TA_KEY2) begin
      ta_stage_r <= 2'd2;
      ta_cnt_r   <= 2'(TA_WINDOW);
    end else if (w_watchdog_control || ta_cnt_r == 2'd0) begin
      ta_stage_r <= 2'd0;
      ta_cnt_r   <= 2'd0;
    end else begin
      ta_cnt_r   <= ta_cnt_r - 2'd1;
    end
  end

  // in-service tracking; a nested high routine returns to low
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      in_lo_r  <= 1'b0;
      in_hi_r  <= 1'b0;
      lo_pre_r <= 1'b0;
      req_r    <= 1'b0;
      src_r    <= NO_SRC;
    end else begin
      if (ack && req_r) begin
        if (hi[src_r]) begin
          in_hi_r  <= 1'b1;
          lo_pre_r <= in_lo_r;
        end else begin
          in_lo_r  <= 1'b1;
        end
      end else if (bus.reti) begin
        if (in_hi_r) begin
          in_hi_r <= 1'b0;
          in_lo_r <= lo_pre_r;
        end else begin
          in_lo_r <= 1'b0;
        end
      end
      // request drops for the cycle after an ack so state settles
      req_r <= arb_v && !ack && !bus.reti;
      src_r <= (ack || bus.reti) ? src_r : arb_src;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  wire [7:0] rd_mux =
    bus.addr == TCON_ADDR     ? tcon_r  :
    bus.addr == SERIAL_PORT_CONTROL_ADDR     ? serial_port_control_r  :
    bus.addr == IE_ADDR       ? ie_r    :
    bus.addr == IP_ADDR       ? ip_r    :
    bus.addr == EXT_EN_ADDR   ? xen_r   :
    bus.addr == EXT_PRIO_ADDR ? xpri_r  :
    bus.addr == EXT_PEND_ADDR ? xpend_r :
    bus.addr == WATCHDOG_CONTROL_ADDR    ? watchdog_control_r : 8'h00;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_r     <= 8'h00;
      ta_open_out <= 1'b0;
    end else begin
      rdata_r     <= bus.rd ? rd_mux : 8'h00;
      ta_open_out <= ta_stage_r == 2'd2;
    end
  end

  assign bus.rdata   = rdata_r;
  assign bus.irq_req = req_r;
  assign bus.irq_src = src_r;
  assign bus.irq_vec = (src_r < 4'(NSRC)) ? VEC_ADDR[src_r] : 8'h00;
endmodule

// ===== mif_core.sv
// core-side end: forwards software accesses, takes vectors, returns
// assumes the user side acts as service software
`timescale 1ns/100ps
module mif_core
  import mif_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       nrst_in,
  // link to the controller
  mif_bus_if.core         bus,
  // user register port
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic       reti_in,
  output logic [7:0]      rdata_out,
  // vectoring report
  output logic            taken_out,
  output logic [7:0]      vec_out
);
  logic       ack_r, reti_r;

  // accept every request when no ack is in flight
  wire take = bus.irq_req && !ack_r;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_r     <= 1'b0;
      reti_r    <= 1'b0;
      taken_out <= 1'b0;
      vec_out   <= 8'h00;
    end else begin
      ack_r     <= take;
      // watchdog and extended flags are cleared by software
      reti_r    <= reti_in;
      taken_out <= take;
      vec_out   <= take ? bus.irq_vec : vec_out;
    end
  end

  // strobes pass straight through so read data stand one cycle after rd
  assign bus.addr    = addr_in;
  assign bus.wdata   = wdata_in;
  assign bus.wr      = wr_in;
  assign bus.rd      = rd_in;
  assign bus.irq_ack = ack_r;
  assign bus.reti    = reti_r;
  // read data come straight from the controller's read register
  assign rdata_out   = bus.rdata;
endmodule

// ===== mif_assertions.sv
// checks on the link between the interrupt block and its core-side end
// assumes it is instantiated beside the interface and fed its signals
`timescale 1ns/100ps
module mif_assertions
  import mif_pkg::*;
(
  // clock and reset
  input wire logic       ref_clk_in,
  input wire logic       nrst_in,
  // link signals
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       irq_req,
  input wire logic [7:0] irq_vec,
  input wire logic [3:0] irq_src,
  input wire logic       irq_ack,
  input wire logic       reti
);
  // ----------------------------------------
  // shadow registers
  // ----------------------------------------
  localparam logic [7:0] EXT_MASK = 8'h1b;
  logic       ea_r;
  logic [7:0] en_r;
  logic [7:0] pr_r;
  wire        wr_ie = wr && addr == IE_ADDR;
  wire        wr_en = wr && addr == EXT_EN_ADDR;
  wire        wr_pr = wr && addr == EXT_PRIO_ADDR;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ea_r <= 1'b0;
      en_r <= REG_RESET;
      pr_r <= REG_RESET;
    end else begin
      if (wr_ie) ea_r <= wdata[IE_EA];
      if (wr_en) en_r <= wdata & EXT_MASK;
      if (wr_pr) pr_r <= wdata & EXT_MASK;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_take;
    irq_req ##1 irq_ack;
  endsequence
  sequence s_rd(logic [7:0] a);
    rd && addr == a;
  endsequence

  property p_vec_map;
    irq_req |-> irq_src < 4'h9 && irq_vec == VEC_ADDR[irq_src];
  endproperty
  property p_ea_gate;
    $rose(irq_req) |-> $past(ea_r);
  endproperty
  property p_ack_cause;
    irq_ack |-> $past(irq_req);
  endproperty
  property p_ack_drop;
    s_take |=> !irq_req;
  endproperty
  property p_rd_en;
    s_rd(EXT_EN_ADDR) |=> rdata == $past(en_r);
  endproperty
  property p_rd_pr;
    s_rd(EXT_PRIO_ADDR) |=> rdata == $past(pr_r);
  endproperty
  property p_rd_ea;
    s_rd(IE_ADDR) |=> rdata[IE_EA] == $past(ea_r);
  endproperty
  property p_rd_pend;
    s_rd(EXT_PEND_ADDR) |=> rdata[7:4] == 4'h0 && !rdata[X_SRC4];
  endproperty
  property p_rd_wd;
    s_rd(WATCHDOG_CONTROL_ADDR) |=> rdata[7:4] == 4'h0;
  endproperty

  a_vec_map: assert property (p_vec_map) else $error("vector does not match source");
  a_ea_gate: assert property (p_ea_gate) else $error("request raised while masked");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_ack_drop: assert property (p_ack_drop) else $error("request stays after ack");
  a_rd_en: assert property (p_rd_en) else $error("enable readback wrong");
  a_rd_pr: assert property (p_rd_pr) else $error("priority readback wrong");
  a_rd_ea: assert property (p_rd_ea) else $error("global enable readback wrong");
  a_rd_pend: assert property (p_rd_pend) else $error("pending reserved bits set");
  a_rd_wd: assert property (p_rd_wd) else $error("watchdog upper bits set");
endmodule

// ===== testbench.sv
// self-checking bench: both ends joined, user side driven as software
// assumes the reference model below mirrors the readable registers
`timescale 1ns/100ps
module testbench;
  import mif_pkg::*;
  logic       ref_clk_in, nrst_in, wr_in, rd_in, reti_in;
  logic [7:0] addr_in, wdata_in;
  logic [4:0] pins_n, ev;
  logic [7:0] rdata_out, vec_out;
  logic       taken_out, ta_open_out;
  logic [7:0] m [256];
  logic [7:0] exp_q [$];
  logic [31:0] seed;
  int         errors, num_checks;

  mif_bus_if mif_bus_if_inst ();
  mif_dev mif_dev_inst (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .bus(mif_bus_if_inst),
    .ext0_n_in(pins_n[0]), .ext1_n_in(pins_n[1]), .ext2_n_in(pins_n[2]),
    .ext3_n_in(pins_n[3]), .net_irq_n_in(pins_n[4]), .tmr0_ovf_in(ev[0]),
    .tmr1_ovf_in(ev[1]), .uart_rx_in(ev[2]), .uart_tx_in(ev[3]), .wdog_evt_in(ev[4]),
    .ta_open_out(ta_open_out));
  mif_core mif_core_inst (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .bus(mif_bus_if_inst),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .reti_in(reti_in), .rdata_out(rdata_out), .taken_out(taken_out), .vec_out(vec_out));
  mif_assertions mif_assertions_inst (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .addr(mif_bus_if_inst.addr), .wdata(mif_bus_if_inst.wdata), .wr(mif_bus_if_inst.wr),
    .rd(mif_bus_if_inst.rd), .rdata(mif_bus_if_inst.rdata),
    .irq_req(mif_bus_if_inst.irq_req), .irq_vec(mif_bus_if_inst.irq_vec),
    .irq_src(mif_bus_if_inst.irq_src), .irq_ack(mif_bus_if_inst.irq_ack),
    .reti(mif_bus_if_inst.reti));

  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic test_done();
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // watchdog control writes only land through the key sequence
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
    if (a != WATCHDOG_CONTROL_ADDR) m[a] = d & ((a == EXT_PEND_ADDR) ? 8'h0b :
      (a == EXT_EN_ADDR || a == EXT_PRIO_ADDR) ? 8'h1b : 8'hff);
  endtask
  task automatic rd_chk(logic [7:0] a);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), m[a], rdata_out);
  endtask
  task automatic ta_wr(logic [7:0] d);
    wr(TA_ADDR, TA_KEY1);
    wr(TA_ADDR, TA_KEY2);
    wr(WATCHDOG_CONTROL_ADDR, d);
    m[WATCHDOG_CONTROL_ADDR] = d;
  endtask
  task automatic take_chk();
    logic [7:0] e;
    int         n;
    e = exp_q.pop_front();
    n = 0;
    do begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end while (taken_out !== 1'b1 && n < 40);
    chk("taken", 8'h01, {7'h0, taken_out});
    if (taken_out !== 1'b1) begin
      test_done();
    end else begin
      chk("vector", e, vec_out);
    end
  endtask
  task automatic none_chk(int n);
    repeat (n) begin
      @(posedge ref_clk_in);
      #1;
      chk("taken", 8'h00, {7'h0, taken_out});
    end
  endtask
  task automatic pin(int i, logic v);
    @(posedge ref_clk_in);
    pins_n[i] <= v;
  endtask
  task automatic pulse(int i);
    @(posedge ref_clk_in);
    ev[i] <= 1'b1;
    @(posedge ref_clk_in);
    ev[i] <= 1'b0;
  endtask
  task automatic ret();
    @(posedge ref_clk_in);
    reti_in <= 1'b1;
    @(posedge ref_clk_in);
    reti_in <= 1'b0;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {nrst_in, wr_in, rd_in, reti_in, addr_in, wdata_in, ev} = '0;
    pins_n = 5'h1f;
    seed = 32'ha41a2557;
    foreach (m[i]) m[i] = 8'h00;
    repeat (16) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    for (int i = 0; i < NSRC; i++) rd_chk(8'h88 + 8'(i * 8));
    rd_chk(EXT_PEND_ADDR);
    rd_chk(EXT_EN_ADDR);
    rd_chk(EXT_PRIO_ADDR);
    rd_chk(WATCHDOG_CONTROL_ADDR);
    repeat (8) begin
      seed = xs(seed);
      // software keeps the reserved source-4 bit clear
      wr(EXT_EN_ADDR, seed[7:0] & 8'hfb);
      wr(EXT_PRIO_ADDR, seed[15:8] & 8'hfb);
      rd_chk(EXT_EN_ADDR);
      rd_chk(EXT_PRIO_ADDR);
    end
    wr(EXT_EN_ADDR, 8'h00);
    wr(EXT_PRIO_ADDR, 8'h00);
    // level mode: flag mirrors the pin
    pin(1, 1'b0);
    m[TCON_ADDR] = 8'h08;
    rd_chk(TCON_ADDR);
    pin(1, 1'b1);
    m[TCON_ADDR] = 8'h00;
    rd_chk(TCON_ADDR);
    // edge mode on both pins; flag must not re-arm while the pin stays low
    wr(TCON_ADDR, 8'h05);
    for (int i = 0; i < 2; i++) begin
      wr(IE_ADDR, 8'h80 | (8'h01 << (i * 2)));
      pin(i, 1'b0);
      exp_q.push_back(VEC_ADDR[i * 2]);
      take_chk();
      pin(i, 1'b1);
      rd_chk(TCON_ADDR);
      ret();
    end
    for (int i = 0; i < 2; i++) begin
      wr(IE_ADDR, 8'h80 | (8'h02 << (i * 2)));
      pulse(i);
      exp_q.push_back(VEC_ADDR[i * 2 + 1]);
      take_chk();
      rd_chk(TCON_ADDR);
      ret();
    end
    wr(IE_ADDR, 8'h00);
    pulse(2);
    m[SERIAL_PORT_CONTROL_ADDR] = 8'h01;
    rd_chk(SERIAL_PORT_CONTROL_ADDR);
    pulse(3);
    m[SERIAL_PORT_CONTROL_ADDR] = 8'h03;
    rd_chk(SERIAL_PORT_CONTROL_ADDR);
    wr(IE_ADDR, 8'h90);
    exp_q.push_back(VEC_ADDR[4]);
    take_chk();
    wr(SERIAL_PORT_CONTROL_ADDR, 8'h00);
    ret();
    // two equal-level sources held back by the global mask
    wr(IE_ADDR, 8'h00);
    wr(EXT_EN_ADDR, 8'h03);
    pin(2, 1'b0);
    pin(3, 1'b0);
    m[EXT_PEND_ADDR] = 8'h03;
    none_chk(10);
    rd_chk(EXT_PEND_ADDR);
    wr(IE_ADDR, 8'h80);
    exp_q.push_back(VEC_ADDR[5]);
    take_chk();
    rd_chk(EXT_PEND_ADDR);
    wr(EXT_PEND_ADDR, 8'h02);
    ret();
    exp_q.push_back(VEC_ADDR[6]);
    take_chk();
    wr(EXT_PEND_ADDR, 8'h00);
    ret();
    // high level watchdog pre-empts the low level network routine
    wr(EXT_EN_ADDR, 8'h18);
    wr(EXT_PRIO_ADDR, 8'h10);
    pin(4, 1'b0);
    exp_q.push_back(VEC_ADDR[7]);
    take_chk();
    pulse(4);
    exp_q.push_back(VEC_ADDR[8]);
    take_chk();
    m[WATCHDOG_CONTROL_ADDR] = 8'h08;
    rd_chk(WATCHDOG_CONTROL_ADDR);
    ta_wr(8'h00);
    rd_chk(WATCHDOG_CONTROL_ADDR);
    ret();
    wr(EXT_PEND_ADDR, 8'h00);
    ret();
    // stale key window must refuse the write
    wr(TA_ADDR, TA_KEY1);
    wr(TA_ADDR, TA_KEY2);
    @(posedge ref_clk_in);
    #1;
    chk("ta_open", 8'h01, {7'h0, ta_open_out});
    repeat (6) @(posedge ref_clk_in);
    #1;
    chk("ta_open", 8'h00, {7'h0, ta_open_out});
    wr(WATCHDOG_CONTROL_ADDR, 8'h08);
    rd_chk(WATCHDOG_CONTROL_ADDR);
    ta_wr(8'h08);
    exp_q.push_back(VEC_ADDR[8]);
    take_chk();
    ta_wr(8'h00);
    ret();
    rd_chk(WATCHDOG_CONTROL_ADDR);
    test_done();
  end
endmodule
